//--- rtl/pwq_regs.svh
`ifndef PWQ_REGS_SVH
`define PWQ_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define PWQ_ADDR_PIPE3      5'h14
`define PWQ_ADDR_PIPE4      5'h15
`define PWQ_ADDR_PIPE5      5'h16
`define PWQ_ADDR_FLAGS      5'h17
// ****************************************
// Occupancy flag and pipe width fields and resets
// ****************************************
`define PWQ_BIT_RX_EMPTY    0
`define PWQ_BIT_RX_FULL     1
`define PWQ_BIT_TX_EMPTY    4
`define PWQ_BIT_TX_FULL     5
`define PWQ_BIT_TX_REUSE    6
`define PWQ_WIDTH_MSB       5
`define PWQ_WIDTH_RESET     6'h00
`define PWQ_FLAGS_RESET     8'h11
// ****************************************
// Command codes
// ****************************************
`define PWQ_OP_RREG         3'h0
`define PWQ_OP_WREG         3'h1
`define PWQ_OP_RD_RX        8'h80
`define PWQ_OP_WR_TX        8'h81
`define PWQ_OP_FLUSH_TX     8'h82
`define PWQ_OP_FLUSH_RX     8'h83
`define PWQ_OP_REUSE        8'h84
// ****************************************
// Queue shape and timing
// ****************************************
`define PWQ_SLOTS           3
`define PWQ_MAX_PLD         32
`define PWQ_CLK_NS          10
`define PWQ_CE_MIN_NS       10000
`define PWQ_CE_MIN_CYC      ((`PWQ_CE_MIN_NS + `PWQ_CLK_NS - 1) / `PWQ_CLK_NS)
`endif

//--- rtl/pwq_pkg.sv
`include "pwq_regs.svh"
package pwq_pkg;
   typedef enum logic [2:0] {
      CMD_NONE, CMD_RREG, CMD_WREG, CMD_RD_RX, CMD_WR_TX, CMD_FLUSH_TX, CMD_FLUSH_RX, CMD_REUSE
   } pwq_cmd_t;

   function automatic pwq_cmd_t pwq_decode(input logic [7:0] op);
      pwq_cmd_t c;
      c = CMD_NONE;
      if (op[7:5] == `PWQ_OP_RREG) c = CMD_RREG;
      else if (op[7:5] == `PWQ_OP_WREG) c = CMD_WREG;
      else if (op == `PWQ_OP_RD_RX) c = CMD_RD_RX;
      else if (op == `PWQ_OP_WR_TX) c = CMD_WR_TX;
      else if (op == `PWQ_OP_FLUSH_TX) c = CMD_FLUSH_TX;
      else if (op == `PWQ_OP_FLUSH_RX) c = CMD_FLUSH_RX;
      else if (op == `PWQ_OP_REUSE) c = CMD_REUSE;
      return c;
   endfunction : pwq_decode

   // Slot and byte index to memory address
   function automatic logic [6:0] pwq_addr(input logic [1:0] slot, input logic [4:0] idx);
      return {slot, idx};
   endfunction : pwq_addr

   // Slot pointer wraps after the third slot
   function automatic logic [1:0] pwq_next_slot(input logic [1:0] slot);
      return (slot == 2'h2) ? 2'h0 : slot + 2'h1;
   endfunction : pwq_next_slot
endpackage : pwq_pkg

//--- rtl/pwq_mem_if.sv
`timescale 1ns/1ns
interface pwq_mem_if;
   logic       we;
   logic [6:0] waddr;
   logic [7:0] wdata;
   logic [6:0] raddr;
   logic [7:0] rdata;
   modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : pwq_mem_if

//--- rtl/pwq_mem.sv
`timescale 1ns/1ns
module pwq_mem #(
   parameter int DEPTH = 96
) (
   input wire logic CORE_CLK,
   pwq_mem_if.mem   port
);
   logic [7:0] store [DEPTH];

   // Read data registered so every consumer sees a flop output
   always_ff @(posedge CORE_CLK) begin
      if (port.we) begin
         store[port.waddr] <= port.wdata;
      end
      port.rdata <= store[port.raddr];
   end
endmodule : pwq_mem

//--- rtl/pwq_top.sv
// Function
// - Pipe width field bits 5:0 sets fixed payload bytes 1..32; 0 means unused; values 33..63 are stored and read back as written too
// - Resend command sets resend flag, bit 6 of occupancy register
// - Resend and its flag work only as primary transmitter
// - Bit 5 reads 1 when transmit queue full; resets to 0
// - Bit 1 reads 1 when receive queue full; resets to 0
// - Transmit queue holds three payloads of 1..32 bytes, transmit use only
// - Receive queue is one three-level queue shared by all pipes
`timescale 1ns/1ns
`include "pwq_regs.svh"
module pwq_top
   import pwq_pkg::*;
#(
   parameter int CE_CYC = `PWQ_CE_MIN_CYC
) (
   // Clock and reset
   input  wire logic       CORE_CLK,
   input  wire logic       RST,
   // Serial command port, one byte per beat
   input  wire logic       CMD_VALID,
   input  wire logic [7:0] CMD_OP,
   input  wire logic [7:0] CMD_WDATA,
   input  wire logic       CMD_LAST,
   output logic            RSP_VALID,
   output logic      [7:0] RSP_DATA,
   // Mode and chip enable
   input  wire logic       PRIMARY_TX,
   input  wire logic       CHIP_EN,
   output logic            TX_RESEND,
   // Radio receive side
   input  wire logic       RX_WR_VALID,
   input  wire logic [7:0] RX_WR_DATA,
   input  wire logic       RX_WR_LAST,
   output logic            RX_WR_READY,
   // Radio transmit side
   input  wire logic       TX_RD_REQ,
   input  wire logic       TX_RD_DONE,
   output logic            TX_RD_VALID,
   output logic      [7:0] TX_RD_DATA,
   // Pipe widths
   output logic      [5:0] PIPE3_WIDTH,
   output logic      [5:0] PIPE4_WIDTH,
   output logic      [5:0] PIPE5_WIDTH
);
   localparam int CW = $clog2(CE_CYC + 1);

   pwq_mem_if tx_if ();
   pwq_mem_if rx_if ();
   pwq_mem #(.DEPTH(`PWQ_SLOTS * `PWQ_MAX_PLD)) u_tx_mem (.CORE_CLK(CORE_CLK), .port(tx_if.mem));
   pwq_mem #(.DEPTH(`PWQ_SLOTS * `PWQ_MAX_PLD)) u_rx_mem (.CORE_CLK(CORE_CLK), .port(rx_if.mem));

   pwq_cmd_t   cmd;
   logic [4:0] reg_addr;
   logic       reuse_reg;
   logic [1:0] tx_cnt_reg, tx_wslot_reg, tx_rslot_reg, tx_last_reg;
   logic [5:0] tx_widx_reg;
   logic [4:0] tx_ridx_reg;
   logic [1:0] rx_cnt_reg, rx_cnt_next, rx_wslot_reg, rx_rslot_reg;
   logic [5:0] rx_widx_reg;
   logic [4:0] rx_ridx_reg;
   logic       tx_push, tx_pop, rx_push, rx_pop, tx_wr_ok, rx_wr_ok;
   logic [7:0] flags;
   logic [7:0] reg_q_reg;
   logic       rd_pend_reg, rd_pay_reg;
   logic [CW-1:0] ce_cnt_reg;

   assign cmd      = CMD_VALID ? pwq_decode(CMD_OP) : CMD_NONE;
   assign reg_addr = CMD_OP[4:0];

   // ****************************************
   // Occupancy flags
   // ****************************************
   always_comb begin
      flags                     = 8'h00;
      flags[`PWQ_BIT_TX_REUSE]  = reuse_reg;
      flags[`PWQ_BIT_TX_FULL]   = (tx_cnt_reg == 2'h3);
      flags[`PWQ_BIT_TX_EMPTY]  = (tx_cnt_reg == 2'h0);
      flags[`PWQ_BIT_RX_FULL]   = (rx_cnt_reg == 2'h3);
      flags[`PWQ_BIT_RX_EMPTY]  = (rx_cnt_reg == 2'h0);
   end

   // ****************************************
   // Pipe width registers
   // ****************************************
   // Upper bits are reserved and read back as zero
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         PIPE3_WIDTH <= `PWQ_WIDTH_RESET;
         PIPE4_WIDTH <= `PWQ_WIDTH_RESET;
         PIPE5_WIDTH <= `PWQ_WIDTH_RESET;
      end else if (cmd == CMD_WREG) begin
         case (reg_addr)
            `PWQ_ADDR_PIPE3: PIPE3_WIDTH <= CMD_WDATA[`PWQ_WIDTH_MSB:0];
            `PWQ_ADDR_PIPE4: PIPE4_WIDTH <= CMD_WDATA[`PWQ_WIDTH_MSB:0];
            `PWQ_ADDR_PIPE5: PIPE5_WIDTH <= CMD_WDATA[`PWQ_WIDTH_MSB:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Resend flag
   // ****************************************
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         reuse_reg <= 1'b0;
      end else if (cmd == CMD_REUSE && PRIMARY_TX) begin
         reuse_reg <= 1'b1;
      end else if (cmd == CMD_WR_TX || cmd == CMD_FLUSH_TX) begin
         reuse_reg <= 1'b0;
      end
   end

   // Counter saturates, so one pulse per chip enable high period
   always_ff @(posedge CORE_CLK) begin
      if (RST || !(CHIP_EN && reuse_reg && PRIMARY_TX)) begin
         ce_cnt_reg <= '0;
      end else if (ce_cnt_reg != CW'(CE_CYC)) begin
         ce_cnt_reg <= ce_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         TX_RESEND <= 1'b0;
      end else begin
         TX_RESEND <= CHIP_EN && reuse_reg && PRIMARY_TX
                      && (ce_cnt_reg == CW'(CE_CYC - 1));
      end
   end

   // ****************************************
   // Transmit queue
   // ****************************************
   // Writes into a full queue are dropped, bytes past 32 are ignored
   assign tx_wr_ok = (cmd == CMD_WR_TX) && (tx_cnt_reg != 2'h3);
   assign tx_push  = tx_wr_ok && CMD_LAST;
   assign tx_pop   = TX_RD_DONE && !reuse_reg && (tx_cnt_reg != 2'h0);
   assign tx_if.we    = tx_wr_ok && (tx_widx_reg < 6'(`PWQ_MAX_PLD));
   assign tx_if.waddr = pwq_addr(tx_wslot_reg, tx_widx_reg[4:0]);
   assign tx_if.wdata = CMD_WDATA;
   // Resend replays the slot last handed to the radio
   assign tx_if.raddr = pwq_addr(reuse_reg ? tx_last_reg : tx_rslot_reg, tx_ridx_reg);

   always_ff @(posedge CORE_CLK) begin
      if (RST || cmd == CMD_FLUSH_TX) begin
         tx_cnt_reg   <= 2'h0;
         tx_wslot_reg <= 2'h0;
         tx_rslot_reg <= 2'h0;
         tx_widx_reg  <= 6'h00;
      end else begin
         if (tx_push) begin
            tx_wslot_reg <= pwq_next_slot(tx_wslot_reg);
            tx_widx_reg  <= 6'h00;
         end else if (tx_wr_ok && tx_widx_reg < 6'(`PWQ_MAX_PLD)) begin
            tx_widx_reg  <= tx_widx_reg + 6'h01;
         end
         if (tx_pop) begin
            tx_rslot_reg <= pwq_next_slot(tx_rslot_reg);
         end
         tx_cnt_reg <= tx_cnt_reg + {1'b0, tx_push} - {1'b0, tx_pop};
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         tx_ridx_reg <= 5'h00;
         tx_last_reg <= 2'h0;
         TX_RD_VALID <= 1'b0;
      end else begin
         TX_RD_VALID <= TX_RD_REQ;
         if (TX_RD_DONE) begin
            tx_ridx_reg <= 5'h00;
         end else if (TX_RD_REQ) begin
            tx_ridx_reg <= tx_ridx_reg + 5'h01;
         end
         if (tx_pop) begin
            tx_last_reg <= tx_rslot_reg;
         end
      end
   end
   assign TX_RD_DATA = tx_if.rdata;

   // ****************************************
   // Receive queue
   // ****************************************
   // One queue for every pipe; the radio stalls on ready rather than lose data
   assign rx_wr_ok = RX_WR_VALID && RX_WR_READY;
   assign rx_push  = rx_wr_ok && RX_WR_LAST;
   assign rx_pop   = (cmd == CMD_RD_RX) && CMD_LAST && (rx_cnt_reg != 2'h0);
   assign rx_cnt_next = (cmd == CMD_FLUSH_RX) ? 2'h0
                      : rx_cnt_reg + {1'b0, rx_push} - {1'b0, rx_pop};
   assign rx_if.we    = rx_wr_ok && (rx_widx_reg < 6'(`PWQ_MAX_PLD));
   assign rx_if.waddr = pwq_addr(rx_wslot_reg, rx_widx_reg[4:0]);
   assign rx_if.wdata = RX_WR_DATA;
   assign rx_if.raddr = pwq_addr(rx_rslot_reg, rx_ridx_reg);

   always_ff @(posedge CORE_CLK) begin
      if (RST || cmd == CMD_FLUSH_RX) begin
         rx_cnt_reg   <= 2'h0;
         rx_wslot_reg <= 2'h0;
         rx_rslot_reg <= 2'h0;
         rx_widx_reg  <= 6'h00;
         rx_ridx_reg  <= 5'h00;
         RX_WR_READY  <= !RST;
      end else begin
         rx_cnt_reg  <= rx_cnt_next;
         RX_WR_READY <= (rx_cnt_next != 2'h3);
         if (rx_push) begin
            rx_wslot_reg <= pwq_next_slot(rx_wslot_reg);
            rx_widx_reg  <= 6'h00;
         end else if (rx_wr_ok && rx_widx_reg < 6'(`PWQ_MAX_PLD)) begin
            rx_widx_reg  <= rx_widx_reg + 6'h01;
         end
         if (rx_pop) begin
            rx_rslot_reg <= pwq_next_slot(rx_rslot_reg);
            rx_ridx_reg  <= 5'h00;
         end else if (cmd == CMD_RD_RX) begin
            rx_ridx_reg  <= rx_ridx_reg + 5'h01;
         end
      end
   end

   // ****************************************
   // Read response, two cycles after the beat
   // ****************************************
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rd_pend_reg <= 1'b0;
         rd_pay_reg  <= 1'b0;
         reg_q_reg   <= 8'h00;
         RSP_VALID   <= 1'b0;
         RSP_DATA    <= 8'h00;
      end else begin
         rd_pend_reg <= (cmd == CMD_RREG) || (cmd == CMD_RD_RX);
         rd_pay_reg  <= (cmd == CMD_RD_RX);
         case (reg_addr)
            `PWQ_ADDR_PIPE3: reg_q_reg <= {2'b00, PIPE3_WIDTH};
            `PWQ_ADDR_PIPE4: reg_q_reg <= {2'b00, PIPE4_WIDTH};
            `PWQ_ADDR_PIPE5: reg_q_reg <= {2'b00, PIPE5_WIDTH};
            `PWQ_ADDR_FLAGS: reg_q_reg <= flags;
            default:         reg_q_reg <= 8'h00;
         endcase
         RSP_VALID <= rd_pend_reg;
         RSP_DATA  <= rd_pay_reg ? rx_if.rdata : reg_q_reg;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence seq_flags_read;
      cmd == CMD_RREG && reg_addr == `PWQ_ADDR_FLAGS;
   endsequence
   sequence seq_resend_armed;
      cmd == CMD_REUSE && PRIMARY_TX;
   endsequence

   AST_WIDTH_WRITE: assert property (
      cmd == CMD_WREG && reg_addr == `PWQ_ADDR_PIPE4 |=> PIPE4_WIDTH == $past(CMD_WDATA[5:0]))
      else $error("pipe width not stored");
   AST_RESEND_SET: assert property (
      seq_resend_armed ##1 !CMD_VALID ##1 seq_flags_read |-> ##2 RSP_VALID && RSP_DATA[6])
      else $error("resend flag not reported");
   AST_RESEND_CLEAR: assert property (
      reuse_reg && (cmd == CMD_WR_TX || cmd == CMD_FLUSH_TX) |=> !reuse_reg)
      else $error("resend not cleared");
   AST_RESEND_HOLD: assert property (
      reuse_reg && cmd != CMD_WR_TX && cmd != CMD_FLUSH_TX |=> reuse_reg)
      else $error("resend dropped early");
   AST_RESEND_PTX: assert property (
      !reuse_reg && !PRIMARY_TX |=> !reuse_reg && !TX_RESEND)
      else $error("resend outside primary transmitter");
   AST_CE_PULSE: assert property (
      TX_RESEND |-> $past(CHIP_EN) && $past(ce_cnt_reg) == CW'(CE_CYC - 1))
      else $error("resend pulse before minimum chip enable time");
   AST_TX_FULL: assert property (
      seq_flags_read |-> ##2 RSP_DATA[5] == $past(tx_cnt_reg == 2'h3, 2))
      else $error("transmit full flag wrong");
   // Ready is held low through reset, so the first edge after release is skipped
   AST_RX_FULL: assert property (
      !$past(RST) |-> RX_WR_READY == (rx_cnt_reg != 2'h3))
      else $error("receive full and ready disagree");
   AST_EMPTY_FLUSH: assert property (
      cmd == CMD_FLUSH_TX ##1 seq_flags_read |-> ##2 RSP_DATA[4] && !RSP_DATA[5])
      else $error("transmit empty flag wrong after discard");
   AST_TX_DEPTH: assert property (
      tx_cnt_reg == 2'h3 && !tx_pop && cmd != CMD_FLUSH_TX |=> tx_cnt_reg == 2'h3)
      else $error("full transmit queue changed depth");
   AST_RX_DEPTH: assert property (
      rx_push && !rx_pop && cmd != CMD_FLUSH_RX |=> rx_cnt_reg == $past(rx_cnt_reg) + 2'h1)
      else $error("receive push not counted");
endmodule : pwq_top

//--- sim/pwq_host.sv
`timescale 1ns/1ns
// ****************************************
// Host model on the serial command port
// ****************************************
`include "pwq_regs.svh"
module pwq_host (
   // Clock and answers
   input  wire logic       CORE_CLK,
   input  wire logic       RSP_VALID,
   input  wire logic [7:0] RSP_DATA,
   // Command beats and chip enable
   output logic            CMD_VALID,
   output logic      [7:0] CMD_OP,
   output logic      [7:0] CMD_WDATA,
   output logic            CMD_LAST,
   output logic            CHIP_EN
);
   initial begin
      CMD_VALID = 1'b0;
      CMD_OP    = 8'h00;
      CMD_WDATA = 8'h00;
      CMD_LAST  = 1'b0;
      CHIP_EN   = 1'b0;
   end

   task automatic beat(input logic [7:0] op, input logic [7:0] d, input logic last);
      @(posedge CORE_CLK);
      CMD_VALID <= 1'b1;
      CMD_OP    <= op;
      CMD_WDATA <= d;
      CMD_LAST  <= last;
   endtask : beat

   // Released lines flip so a stale byte never looks current
   task automatic idle();
      @(posedge CORE_CLK);
      CMD_VALID <= 1'b0;
      CMD_OP    <= ~CMD_OP;
      CMD_WDATA <= ~CMD_WDATA;
      CMD_LAST  <= ~CMD_LAST;
   endtask : idle

   task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d  = 8'h00;
      beat({`PWQ_OP_RREG, a}, 8'h00, 1'b0);
      idle();
      for (int i = 0; i < 4; i++) begin
         @(posedge CORE_CLK);
         #1;
         if (RSP_VALID === 1'b1 && ok === 1'b0) begin
            d  = RSP_DATA;
            ok = 1'b1;
         end
      end
   endtask : rd

   // Held well past the minimum so one retransmission is asked when resend is armed as primary transmitter
   task automatic ce_pulse(input int n);
      @(posedge CORE_CLK);
      CHIP_EN <= 1'b1;
      repeat (n) @(posedge CORE_CLK);
      CHIP_EN <= 1'b0;
   endtask : ce_pulse
endmodule : pwq_host

//--- sim/tb_top.sv
`timescale 1ns/1ns
`include "pwq_regs.svh"
module tb_top;
   // ****************************************
   // Signals
   // ****************************************
   logic       CORE_CLK, RST, PRIMARY_TX, RX_WR_VALID, RX_WR_LAST, TX_RD_REQ, TX_RD_DONE;
   logic [7:0] RX_WR_DATA, CMD_OP, CMD_WDATA, RSP_DATA, TX_RD_DATA, d;
   logic       CMD_VALID, CMD_LAST, CHIP_EN, RSP_VALID, TX_RESEND, RX_WR_READY, TX_RD_VALID, ok;
   logic [5:0] PIPE3_WIDTH, PIPE4_WIDTH, PIPE5_WIDTH;
   int         mismatches, checks, resends;

   pwq_top #(.CE_CYC(4)) DUT (.CORE_CLK(CORE_CLK), .RST(RST), .CMD_VALID(CMD_VALID),
      .CMD_OP(CMD_OP), .CMD_WDATA(CMD_WDATA), .CMD_LAST(CMD_LAST), .RSP_VALID(RSP_VALID),
      .RSP_DATA(RSP_DATA), .PRIMARY_TX(PRIMARY_TX), .CHIP_EN(CHIP_EN), .TX_RESEND(TX_RESEND),
      .RX_WR_VALID(RX_WR_VALID), .RX_WR_DATA(RX_WR_DATA), .RX_WR_LAST(RX_WR_LAST),
      .RX_WR_READY(RX_WR_READY), .TX_RD_REQ(TX_RD_REQ), .TX_RD_DONE(TX_RD_DONE),
      .TX_RD_VALID(TX_RD_VALID), .TX_RD_DATA(TX_RD_DATA), .PIPE3_WIDTH(PIPE3_WIDTH),
      .PIPE4_WIDTH(PIPE4_WIDTH), .PIPE5_WIDTH(PIPE5_WIDTH));
   pwq_host host (.CORE_CLK(CORE_CLK), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
      .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_WDATA(CMD_WDATA), .CMD_LAST(CMD_LAST),
      .CHIP_EN(CHIP_EN));

   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end
   always @(posedge CORE_CLK) if (TX_RESEND === 1'b1) resends++;

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // A lost answer ends the run at once
   task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
      host.rd(a, d, ok);
      if (ok !== 1'b1) begin
         mismatches++;
         finish_test();
      end
      chk(d, exp);
   endtask : rdc

   task automatic op(input logic [7:0] c, input logic [7:0] v);
      host.beat(c, v, 1'b0);
      host.idle();
   endtask : op

   task automatic pay(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) host.beat(`PWQ_OP_WR_TX, base + 8'(i), i == n - 1);
      host.idle();
   endtask : pay

   task automatic rxp(input logic [7:0] b);
      @(posedge CORE_CLK);
      RX_WR_VALID <= 1'b1;
      RX_WR_DATA  <= b;
      RX_WR_LAST  <= 1'b0;
      @(posedge CORE_CLK);
      RX_WR_LAST  <= 1'b1;
      @(posedge CORE_CLK);
      RX_WR_VALID <= 1'b0;
      RX_WR_DATA  <= ~RX_WR_DATA;
   endtask : rxp

   task automatic txr(input logic [7:0] exp, input logic done);
      @(posedge CORE_CLK);
      TX_RD_REQ <= 1'b1;
      @(posedge CORE_CLK);
      TX_RD_REQ <= 1'b0;
      // Byte stands for one cycle only, right after the request edge
      #1;
      chk({7'h00, TX_RD_VALID}, 8'h01);
      chk(TX_RD_DATA, exp);
      @(posedge CORE_CLK);
      TX_RD_DONE <= done;
      @(posedge CORE_CLK);
      TX_RD_DONE <= 1'b0;
   endtask : txr

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_widths();
      rdc(5'h17, 8'h11);
      rdc(5'h14, 8'h00);
      op({`PWQ_OP_WREG, 5'h16}, 8'h20);
      op({`PWQ_OP_WREG, 5'h15}, 8'h01);
      op({`PWQ_OP_WREG, 5'h14}, 8'hFF);
      chk({2'h0, PIPE5_WIDTH}, 8'h20);
      chk({2'h0, PIPE4_WIDTH}, 8'h01);
      rdc(5'h14, 8'h3F);
      rdc(5'h15, 8'h01);
      rdc(5'h18, 8'h00);
      op({`PWQ_OP_WREG, 5'h14}, 8'h00);
      // Write lands on the edge that idle returns in
      #1;
      chk({2'h0, PIPE3_WIDTH}, 8'h00);
   endtask : t_widths

   task automatic t_txq();
      pay(1, 8'h10);
      rdc(5'h17, 8'h01);
      pay(32, 8'h20);
      pay(2, 8'h60);
      rdc(5'h17, 8'h21);
      pay(1, 8'h70);
      rdc(5'h17, 8'h21);
      txr(8'h10, 1'b1);
      rdc(5'h17, 8'h01);
      // Discard directly followed by the flag read
      host.beat(`PWQ_OP_FLUSH_TX, 8'h00, 1'b0);
      rdc(5'h17, 8'h11);
   endtask : t_txq

   task automatic t_rxq();
      for (int i = 0; i < 3; i++) rxp(8'(8'h30 + i));
      @(posedge CORE_CLK);
      #1;
      chk({7'h00, RX_WR_READY}, 8'h00);
      rdc(5'h17, 8'h12);
      host.beat(`PWQ_OP_RD_RX, 8'h00, 1'b0);
      host.beat(`PWQ_OP_RD_RX, 8'h00, 1'b1);
      host.idle();
      #1;
      chk({7'h00, RSP_VALID}, 8'h01);
      chk(RSP_DATA, 8'h30);
      @(posedge CORE_CLK);
      #1;
      chk(RSP_DATA, 8'h30);
      rdc(5'h17, 8'h10);
      op(`PWQ_OP_FLUSH_RX, 8'h00);
      rdc(5'h17, 8'h11);
   endtask : t_rxq

   task automatic t_resend();
      pay(1, 8'hA5);
      op(`PWQ_OP_REUSE, 8'h00);
      rdc(5'h17, 8'h01);
      host.ce_pulse(10);
      chk(8'(resends), 8'h00);
      @(posedge CORE_CLK);
      PRIMARY_TX <= 1'b1;
      txr(8'hA5, 1'b1);
      op(`PWQ_OP_REUSE, 8'h00);
      rdc(5'h17, 8'h51);
      txr(8'hA5, 1'b1);
      rdc(5'h17, 8'h51);
      host.ce_pulse(10);
      chk(8'(resends), 8'h01);
      // Flag still set, but no retransmission outside primary transmitter
      @(posedge CORE_CLK);
      PRIMARY_TX <= 1'b0;
      host.ce_pulse(10);
      chk(8'(resends), 8'h01);
      @(posedge CORE_CLK);
      PRIMARY_TX <= 1'b1;
      pay(1, 8'h33);
      rdc(5'h17, 8'h01);
      op(`PWQ_OP_REUSE, 8'h00);
      rdc(5'h17, 8'h41);
      op(`PWQ_OP_FLUSH_TX, 8'h00);
      rdc(5'h17, 8'h11);
   endtask : t_resend

   initial begin
      RST         = 1'b1;
      PRIMARY_TX  = 1'b0;
      RX_WR_VALID = 1'b0;
      RX_WR_DATA  = 8'h00;
      RX_WR_LAST  = 1'b0;
      TX_RD_REQ   = 1'b0;
      TX_RD_DONE  = 1'b0;
      repeat (3) @(posedge CORE_CLK);
      RST <= 1'b0;
      t_widths();
      t_txq();
      t_rxq();
      t_resend();
      finish_test();
   end
endmodule : tb_top
